// file: shared/tick_timer_pkg.sv
// Constants shared by the periodic tick timer design files
package tick_timer_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL_STATUS = 32'hE000_E010;
  localparam logic [31:0] ADDR_RELOAD      = 32'hE000_E014;
  localparam logic [31:0] ADDR_CURRENT     = 32'hE000_E018;
  localparam logic [31:0] ADDR_CALIB       = 32'hE000_E01C;
  localparam logic [31:0] ADDR_IRQ_STATUS  = 32'hE000_E020;
  localparam logic [31:0] ADDR_IRQ_MASK    = 32'hE000_E024;

  // Control and status field positions
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_TICK_INT_BIT = 1;
  localparam int CTRL_CLKSEL_BIT   = 2;
  localparam int CTRL_WRAP_BIT     = 16;

  // Calibration field positions and width
  localparam int CAL_NO_REF_BIT = 31;
  localparam int CAL_SKEW_BIT   = 30;
  localparam int CAL_TEN_MS_W   = 24;

  // Interrupt status bit positions
  localparam int IRQ_WRAP_BIT   = 0;
  localparam int IRQ_NUM_EVENTS = 1;

  // Reset values and fixed contents
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0004;
  localparam logic [31:0] CALIB_RESET       = 32'hC000_0000;
  localparam logic [23:0] TEN_MS_COUNT      = 24'h00_30D4;
  localparam logic [23:0] RELOAD_RESET      = 24'h00_0000;
  localparam logic [23:0] CURRENT_RESET     = 24'h00_0000;
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
  localparam int          COUNT_W_MAX       = 24;

  // Timing: APB answer comes one cycle into the access phase
  localparam int APB_WAIT_CYCLES = 1;
endpackage : tick_timer_pkg

// file: core/ref_edge_sync.sv
// Two-flop synchroniser and rising-edge detector for the reference clock
`timescale 1ns/1ps
module ref_edge_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Asynchronous reference clock
  input  wire logic ref_clk,
  // One-cycle pulse per reference rising edge
  output logic      ref_rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // First flop is read only by the second one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= ref_clk;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_r   <= 1'b0;
      ref_rise <= 1'b0;
    end else begin
      prev_r   <= sync_r;
      ref_rise <= sync_r & ~prev_r;
    end
  end
endmodule : ref_edge_sync

// file: core/tick_counter.sv
// Down counter with reload, clear and wrap detection
`timescale 1ns/1ps
module tick_counter #(
  parameter int COUNT_W = 24
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Control
  input  wire logic               step,
  input  wire logic               load,
  input  wire logic               clear,
  input  wire logic [COUNT_W-1:0] reload_val,
  // Results
  output logic      [COUNT_W-1:0] count,
  output logic                    wrap
);
  localparam logic [COUNT_W-1:0] ONE  = COUNT_W'(1);
  localparam logic [COUNT_W-1:0] ZERO = '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= ZERO;
    end else if (clear) begin
      count <= ZERO;
    end else if (load) begin
      count <= reload_val;
    end else if (step) begin
      if (count == ZERO) begin
        count <= reload_val;
      end else begin
        count <= count - ONE;
      end
    end
  end

  // Only the step from one to zero counts as a wrap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrap <= 1'b0;
    end else begin
      wrap <= step & ~clear & ~load & (count == ONE);
    end
  end
endmodule : tick_counter

// file: core/periodic_tick_timer.sv
// Periodic tick timer: APB registers, clock choice, wrap flag and interrupts
//
// Overview of operation
// - 24-bit counter counts down, reloads after zero
// - Counter holds while core halted for debug
// - Counter freezes while processor clock gated
// - Wrap flag set on zero, cleared by read
// - Clock select: 0 reference, 1 processor
// - Interrupt enable gates tick exception request
// - Enable loads reload then starts counting
// - Reload zero gives no flag, no exception
// - Current read is live; write clears it, flag
// - Calibration bit 31 flags missing reference clock
// - Calibration bit 30 flags inexact ten-ms count
// - Ten-ms field reads fixed calibration constant
`timescale 1ns/1ps
module periodic_tick_timer #(
  parameter int COUNT_W     = 24,
  parameter bit HAS_REF_CLK = 1'b0,
  parameter bit TEN_MS_SKEW = 1'b1
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core state
  input  wire logic        debug_halted,
  input  wire logic        core_clk_gated,
  input  wire logic        ref_clk,
  // Requests
  output logic             tick_request,
  output logic             irq
);
  import tick_timer_pkg::*;

  generate
    if (COUNT_W < 1 || COUNT_W > COUNT_W_MAX) begin : g_bad_width
      $error("COUNT_W must lie between 1 and 24");
    end
  endgenerate

  // Control fields
  logic               enable_r;
  logic               tick_int_en_r;
  logic               clock_select_r;
  logic               wrap_flag_r;
  logic [COUNT_W-1:0] reload_r;
  logic [IRQ_NUM_EVENTS-1:0] irq_status_r;
  logic [IRQ_NUM_EVENTS-1:0] irq_mask_r;
  logic               enable_prev_r;

  // Bus decode
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  logic        hit_ctrl;
  logic        hit_reload;
  logic        hit_current;
  logic        hit_calib;
  logic        hit_irq_st;
  logic        hit_irq_mk;
  logic        mapped;
  logic [31:0] rd_mux;

  // Counter interface
  logic               ref_rise;
  logic               step;
  logic               load;
  logic               clear;
  logic [COUNT_W-1:0] count;
  logic               wrap;
  logic               run_ok;
  logic [31:0]        ctrl_view;
  logic [31:0]        calib_view;

  // A request completes at the edge where pready is already high
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite;
  assign rd_done     = access_done & ~pwrite;

  assign hit_ctrl    = (paddr == ADDR_CTRL_STATUS);
  assign hit_reload  = (paddr == ADDR_RELOAD);
  assign hit_current = (paddr == ADDR_CURRENT);
  assign hit_calib   = (paddr == ADDR_CALIB);
  assign hit_irq_st  = (paddr == ADDR_IRQ_STATUS);
  assign hit_irq_mk  = (paddr == ADDR_IRQ_MASK);
  assign mapped      = hit_ctrl | hit_reload | hit_current | hit_calib
                     | hit_irq_st | hit_irq_mk;

  ref_edge_sync u_ref_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ref_clk  (ref_clk),
    .ref_rise (ref_rise)
  );

  // Halt and clock gating both freeze the count
  assign run_ok = enable_r & ~debug_halted & ~core_clk_gated;

  always_comb begin
    step = 1'b0;
    if (run_ok) begin
      if (clock_select_r) begin
        step = 1'b1;
      end else begin
        step = ref_rise;
      end
    end
  end

  // Loading on the enable's rising edge starts a fresh period
  assign load  = enable_r & ~enable_prev_r;
  assign clear = wr_done & hit_current;

  tick_counter #(
    .COUNT_W (COUNT_W)
  ) u_counter (
    .core_clk   (core_clk),
    .rst        (rst),
    .step       (step),
    .load       (load),
    .clear      (clear),
    .reload_val (reload_r),
    .count      (count),
    .wrap       (wrap)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_prev_r <= 1'b0;
    end else begin
      enable_prev_r <= enable_r;
    end
  end

  // Control register fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_r       <= CTRL_RESET[CTRL_ENABLE_BIT];
      tick_int_en_r  <= CTRL_RESET[CTRL_TICK_INT_BIT];
      clock_select_r <= CTRL_RESET[CTRL_CLKSEL_BIT];
    end else if (wr_done && hit_ctrl) begin
      enable_r      <= pwdata[CTRL_ENABLE_BIT];
      tick_int_en_r <= pwdata[CTRL_TICK_INT_BIT];
      if (HAS_REF_CLK) begin
        clock_select_r <= pwdata[CTRL_CLKSEL_BIT];
      end else begin
        clock_select_r <= 1'b1;
      end
    end
  end

  // Set wins over a read clear or a current-value write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrap_flag_r <= CTRL_RESET[CTRL_WRAP_BIT];
    end else if (wrap) begin
      wrap_flag_r <= 1'b1;
    end else if ((rd_done && hit_ctrl) || clear) begin
      wrap_flag_r <= 1'b0;
    end
  end

  // Reload value, low bits only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reload_r <= RELOAD_RESET[COUNT_W-1:0];
    end else if (wr_done && hit_reload) begin
      reload_r <= pwdata[COUNT_W-1:0];
    end
  end

  // Tick exception request: one-cycle pulse per wrap when enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_request <= 1'b0;
    end else begin
      tick_request <= wrap & tick_int_en_r;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_r <= '0;
    end else begin
      for (int i = 0; i < IRQ_NUM_EVENTS; i++) begin
        if (i == IRQ_WRAP_BIT && wrap) begin
          irq_status_r[i] <= 1'b1;
        end else if (wr_done && hit_irq_st && pwdata[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask_r <= '0;
    end else if (wr_done && hit_irq_mk) begin
      irq_mask_r <= pwdata[IRQ_NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // Read views
  always_comb begin
    ctrl_view                    = READ_ZERO;
    ctrl_view[CTRL_ENABLE_BIT]   = enable_r;
    ctrl_view[CTRL_TICK_INT_BIT] = tick_int_en_r;
    ctrl_view[CTRL_CLKSEL_BIT]   = clock_select_r;
    ctrl_view[CTRL_WRAP_BIT]     = wrap_flag_r;
  end

  always_comb begin
    calib_view                   = READ_ZERO;
    calib_view[CAL_NO_REF_BIT]   = ~HAS_REF_CLK;
    calib_view[CAL_SKEW_BIT]     = TEN_MS_SKEW;
    calib_view[CAL_TEN_MS_W-1:0] = TEN_MS_COUNT;
  end

  always_comb begin
    rd_mux = READ_ZERO;
    if (hit_ctrl) begin
      rd_mux = ctrl_view;
    end else if (hit_reload) begin
      rd_mux[COUNT_W-1:0] = reload_r;
    end else if (hit_current) begin
      rd_mux[COUNT_W-1:0] = count;
    end else if (hit_calib) begin
      rd_mux = calib_view;
    end else if (hit_irq_st) begin
      rd_mux[IRQ_NUM_EVENTS-1:0] = irq_status_r;
    end else if (hit_irq_mk) begin
      rd_mux[IRQ_NUM_EVENTS-1:0] = irq_mask_r;
    end
  end

  // One wait state keeps read data a clean flop output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= READ_ZERO;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? READ_ZERO : rd_mux;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      prdata  <= READ_ZERO;
      pslverr <= 1'b0;
    end
  end

endmodule : periodic_tick_timer

// file: bench/tick_timer_props.sv
// Port-level checks for the periodic tick timer
`timescale 1ns/1ps
module tick_timer_props #(
  parameter bit HAS_REF_CLK = 1'b0,
  parameter bit TEN_MS_SKEW = 1'b1
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core state and requests
  input wire logic        debug_halted,
  input wire logic        core_clk_gated,
  input wire logic        ref_clk,
  input wire logic        tick_request,
  input wire logic        irq
);
  import tick_timer_pkg::*;
  logic mapped;
  logic rd;
  assign mapped = paddr inside {ADDR_CTRL_STATUS, ADDR_RELOAD, ADDR_CURRENT, ADDR_CALIB, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  assign rd = pready && !pwrite;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
  a_data_idle: assert property (!rd |-> prdata == 32'h0) else $error("prdata not idle");
  a_calib_fixed: assert property (rd && paddr == ADDR_CALIB |->
    prdata == {!HAS_REF_CLK, TEN_MS_SKEW, 6'h00, TEN_MS_COUNT}) else $error("calib value");
  a_clksel_one: assert property (rd && paddr == ADDR_CTRL_STATUS && !HAS_REF_CLK |->
    prdata[CTRL_CLKSEL_BIT]) else $error("clock select not one");
  a_ctrl_spare_zero: assert property (rd && paddr == ADDR_CTRL_STATUS |->
    prdata[31:17] == 15'h0 && prdata[15:3] == 13'h0) else $error("ctrl spare bits");
  a_count_width: assert property (rd && (paddr == ADDR_RELOAD || paddr == ADDR_CURRENT) |->
    prdata[31:24] == 8'h00) else $error("count upper bits");
  a_tick_pulse: assert property (tick_request |=> !tick_request) else $error("tick held");
  a_hold_no_tick: assert property ((debug_halted || core_clk_gated) [*3] |-> !tick_request)
    else $error("tick while held");
  c_err: cover property (rd && pslverr);
  c_tick: cover property (tick_request);
  c_irq: cover property (irq);
  c_halt: cover property (debug_halted [*3]);
endmodule : tick_timer_props

bind periodic_tick_timer tick_timer_props #(.HAS_REF_CLK(HAS_REF_CLK), .TEN_MS_SKEW(TEN_MS_SKEW)) u_props (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halted(debug_halted),
  .core_clk_gated(core_clk_gated), .ref_clk(ref_clk), .tick_request(tick_request), .irq(irq));

// file: bench/periodic_tick_timer_test.sv
// Self-checking bench for the periodic tick timer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module periodic_tick_timer_test;
  import tick_timer_pkg::*;
  typedef struct { logic w; logic [31:0] a; logic [31:0] d; logic [31:0] x; logic e; } row_t;
  logic        core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        debug_halted = 1'h0, core_clk_gated = 1'h0, ref_clk = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, c1;
  logic        pready, pslverr, tick_request, irq, er;
  // Second instance with a reference clock present, fed from the same bus
  logic [31:0] prdata_ref, rd2;
  logic        pready_ref, pslverr_ref, tick_request_ref, irq_ref;
  int          bad_count = 0, checks = 0, ticks = 0, cyc = 0, last = 0, prev = 0, t;
  int          r0 = 0, r1 = 0, r2 = 0;
  // Writes answer with zero data, so one expected column serves both directions
  row_t rows [12] = '{
    '{1'h0, ADDR_CTRL_STATUS, 32'h0, 32'h0000_0004, 1'h0}, '{1'h0, ADDR_CALIB, 32'h0, 32'hC000_30D4, 1'h0},
    '{1'h0, ADDR_RELOAD, 32'h0, 32'h0, 1'h0}, '{1'h0, ADDR_CURRENT, 32'h0, 32'h0, 1'h0},
    '{1'h1, ADDR_CALIB, 32'hFFFF_FFFF, 32'h0, 1'h0}, '{1'h0, ADDR_CALIB, 32'h0, 32'hC000_30D4, 1'h0},
    '{1'h1, ADDR_CTRL_STATUS, 32'h0, 32'h0, 1'h0}, '{1'h0, ADDR_CTRL_STATUS, 32'h0, 32'h0000_0004, 1'h0},
    '{1'h1, ADDR_RELOAD, 32'hFFFF_FFFF, 32'h0, 1'h0}, '{1'h0, ADDR_RELOAD, 32'h0, 32'h00FF_FFFF, 1'h0},
    '{1'h1, 32'hE000_E028, 32'h1, 32'h0, 1'h1}, '{1'h0, 32'hE000_E028, 32'h0, 32'h0, 1'h1}};
  periodic_tick_timer #(.COUNT_W(24), .HAS_REF_CLK(1'b1), .TEN_MS_SKEW(1'b1)) dut_ref (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_ref), .pready(pready_ref), .pslverr(pslverr_ref), .debug_halted(debug_halted),
    .core_clk_gated(core_clk_gated), .ref_clk(ref_clk), .tick_request(tick_request_ref), .irq(irq_ref));
  periodic_tick_timer #(.COUNT_W(24), .HAS_REF_CLK(1'b0), .TEN_MS_SKEW(1'b1)) dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_halted(debug_halted),
    .core_clk_gated(core_clk_gated), .ref_clk(ref_clk), .tick_request(tick_request), .irq(irq));
  always #2 core_clk = ~core_clk;
  always #7 ref_clk = ~ref_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (tick_request === 1'h1) begin
      ticks++;
      prev = last;
      last = cyc;
    end
    if (tick_request_ref === 1'h1) begin
      r2 = r1;
      r1 = r0;
      r0 = cyc;
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) begin
        @(posedge core_clk);
      end
      rd = prdata;
      rd2 = prdata_ref;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge core_clk);
    end
  endtask : apb
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask : results
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `CHK(rd, rows[i].x)
      `CHK(er, rows[i].e)
    end
    $display("register table done");
    apb(1'h1, ADDR_RELOAD, 32'h4);
    apb(1'h1, ADDR_CURRENT, 32'h0);
    apb(1'h1, ADDR_IRQ_MASK, 32'h1);
    apb(1'h1, ADDR_CTRL_STATUS, 32'h7);
    repeat (40) @(posedge core_clk);
    `CHK(last - prev, 5)
    `CHK(irq, 1'h1)
    $display("periodic done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) debug_halted <= 1'h1;
      else core_clk_gated <= 1'h1;
      repeat (3) @(posedge core_clk);
      apb(1'h0, ADDR_CURRENT, 32'h0);
      c1 = rd;
      t = ticks;
      repeat (20) @(posedge core_clk);
      apb(1'h0, ADDR_CURRENT, 32'h0);
      `CHK(rd, c1)
      `CHK(ticks, t)
      debug_halted <= 1'h0;
      core_clk_gated <= 1'h0;
      repeat (20) @(posedge core_clk);
    end
    $display("hold done");
    debug_halted <= 1'h1;
    repeat (3) @(posedge core_clk);
    apb(1'h0, ADDR_CTRL_STATUS, 32'h0);
    `CHK(rd[CTRL_WRAP_BIT], 1'h1)
    apb(1'h0, ADDR_CTRL_STATUS, 32'h0);
    `CHK(rd[CTRL_WRAP_BIT], 1'h0)
    apb(1'h1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'h0)
    debug_halted <= 1'h0;
    repeat (20) @(posedge core_clk);
    debug_halted <= 1'h1;
    apb(1'h1, ADDR_CURRENT, 32'h0000_0123);
    apb(1'h0, ADDR_CURRENT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, ADDR_CTRL_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0007)
    apb(1'h1, ADDR_IRQ_STATUS, 32'h1);
    apb(1'h1, ADDR_IRQ_MASK, 32'h0);
    debug_halted <= 1'h0;
    repeat (20) @(posedge core_clk);
    `CHK(irq, 1'h0)
    apb(1'h1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'h1)
    $display("flag and interrupt done");
    apb(1'h1, ADDR_CTRL_STATUS, 32'h5);
    // A pulse launched as the write lands is counted on the apb task's last edge, before this one
    @(posedge core_clk);
    t = ticks;
    repeat (20) @(posedge core_clk);
    `CHK(ticks, t)
    apb(1'h1, ADDR_RELOAD, 32'h0);
    apb(1'h1, ADDR_CURRENT, 32'h0);
    apb(1'h1, ADDR_CTRL_STATUS, 32'h7);
    t = ticks;
    repeat (20) @(posedge core_clk);
    `CHK(ticks, t)
    apb(1'h0, ADDR_CURRENT, 32'h0);
    `CHK(rd, 32'h0)
    $display("quiet cases done");
    apb(1'h1, ADDR_RELOAD, 32'h4);
    apb(1'h1, ADDR_CURRENT, 32'h0);
    apb(1'h1, ADDR_CTRL_STATUS, 32'h3);
    repeat (100) @(posedge core_clk);
    // Ten reference edges span exactly 35 core cycles
    `CHK(r0 - r2, 35)
    apb(1'h0, ADDR_CTRL_STATUS, 32'h0);
    `CHK(rd2[CTRL_CLKSEL_BIT], 1'h0)
    `CHK(rd[CTRL_CLKSEL_BIT], 1'h1)
    apb(1'h0, ADDR_CALIB, 32'h0);
    `CHK(rd2, 32'h4000_30D4)
    $display("reference clock done");
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    apb(1'h0, ADDR_CTRL_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0004)
    `CHK(rd2, 32'h0000_0004)
    $display("second reset done");
    results();
  end
endmodule : periodic_tick_timer_test
